// ### cmf_pkg.sv
package cmf_pkg;

	localparam int CLK_HZ          = 40_000_000;
	localparam int MAX_BITRATE_BPS = 1_000_000;
	localparam int MIN_BIT_CYCLES  = CLK_HZ / MAX_BITRATE_BPS;
	localparam int WAKE_FILTER_NS  = 1000;
	localparam int WAKE_FILTER_CYCLES = (WAKE_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	localparam logic [7:0] BITCFG_MIN   = 8'(MIN_BIT_CYCLES - 1);
	localparam logic [7:0] BITCFG_RST   = 8'h27;
	localparam logic [5:0] WAKE_CNT_MAX = 6'(WAKE_FILTER_CYCLES);
	localparam logic [3:0] IDLE_BITS    = 4'hB;
	localparam logic [3:0] DLC_MAX      = 4'h8;
	localparam logic [1:0] OVL_MAX      = 2'h2;
	localparam logic [1:0] RXM_ANY      = 2'h3;
	localparam logic       DOMINANT     = 1'h0;
	localparam logic       RECESSIVE    = 1'h1;

	// Operating mode codes
	localparam logic [2:0] MODE_NORMAL   = 3'h0;
	localparam logic [2:0] MODE_DISABLE  = 3'h1;
	localparam logic [2:0] MODE_LOOPBACK = 3'h2;
	localparam logic [2:0] MODE_LISTEN   = 3'h3;
	localparam logic [2:0] MODE_INIT     = 3'h4;

	// Word addresses
	localparam logic [6:0] ADDR_CTRL   = 7'h00;
	localparam logic [6:0] ADDR_CFG1   = 7'h01;
	localparam logic [6:0] ADDR_CFG2   = 7'h02;
	localparam logic [6:0] ADDR_INTCFG = 7'h03;
	localparam logic [6:0] ADDR_STATUS = 7'h04;
	localparam logic [6:0] ADDR_RXCON0 = 7'h05;
	localparam logic [6:0] ADDR_TXCON0 = 7'h08;
	localparam logic [6:0] ADDR_FILT0  = 7'h10;
	localparam logic [6:0] ADDR_MASK0  = 7'h16;
	localparam logic [2:0] PAGE_TXMEM  = 3'h2;
	localparam logic [2:0] PAGE_RXMEM  = 3'h3;

	localparam int NUM_TX    = 3;
	localparam int NUM_RX    = 2;
	localparam int NUM_FILT  = 6;
	localparam int FILT_BUF0 = 2;

	// Field positions
	localparam int REQ_LSB    = 8;
	localparam int CUR_LSB    = 5;
	localparam int HI_LSB     = 11;
	localparam int WAKE_LINE_FILTER_ENABLE_BIT = 14;
	localparam int TRANSMIT_REQUEST_BIT_BIT  = 3;
	localparam int TRANSMIT_ABORTED_FLAG_BIT  = 6;
	localparam int RXM_LSB    = 5;
	localparam int RXFUL_BIT  = 7;
	localparam int IDE_BIT    = 30;
	localparam int RTR_BIT    = 29;
	localparam int TEC_LSB    = 8;
	localparam int REC_LSB    = 16;
	localparam int ID_W       = 29;
	localparam int EID_W      = 18;

endpackage

// ### cmf_accept_filter.sv
module cmf_accept_filter
	import cmf_pkg::*;
#(
	parameter int IW = ID_W,
	parameter int EW = EID_W
) (
	input  wire logic [IW-1:0] rxId,
	input  wire logic          rxIde,
	input  wire logic [31:0]   filtWord,
	input  wire logic [31:0]   maskWord,
	input  wire logic          ignoreIde,
	output logic               match
);

	logic [IW-1:0] cmpMask;

	always_comb begin
		// Standard frames compare only the base identifier bits
		cmpMask = rxIde ? {IW{1'b1}} : {{(IW-EW){1'b1}}, {EW{1'b0}}};
		match   = (ignoreIde || (filtWord[IDE_BIT] == rxIde))
			&& (((rxId ^ filtWord[IW-1:0]) & maskWord[IW-1:0] & cmpMask) == '0);
	end

endmodule

// ### cmf_mode_frame_ctrl.sv
module cmf_mode_frame_ctrl
	import cmf_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic [6:0]   regAddr,
	input  wire logic [31:0]  regWrData,
	input  wire logic         regWrEn,
	input  wire logic         regRdEn,
	output logic      [31:0]  regRdData,
	input  wire logic         cpuSleep,
	input  wire logic         netRxLine,
	output logic              canTxOut,
	output logic              canTxOe,
	output logic              pinsOwned,
	output logic              bitTick,
	input  wire logic         engTxBit,
	output logic              engRxBit,
	input  wire logic         engSof,
	input  wire logic         engRxValid,
	input  wire logic         engRxErr,
	input  wire logic [28:0]  engRxId,
	input  wire logic         engRxIde,
	input  wire logic         engRxRtr,
	input  wire logic [3:0]   engRxDlc,
	input  wire logic [63:0]  engRxData,
	input  wire logic         engTxErr,
	input  wire logic         engTxBusy,
	input  wire logic         engTxDone,
	input  wire logic         engOverloadCond,
	output logic              txStart,
	output logic      [28:0]  txId,
	output logic              txIde,
	output logic              txRtr,
	output logic      [3:0]   txDlc,
	output logic      [63:0]  txData,
	output logic              ackEnable,
	output logic              errFlagEnable,
	output logic              errFrameReq,
	output logic              overloadReq,
	output logic              wakeFlag
);

	typedef struct packed {
		logic [2:0]             reqMode;
		logic [2:0]             curMode;
		logic [4:0]             ctrlHi;
		logic [7:0]             bitCfg;
		logic [31:0]            cfg2;
		logic [31:0]            intCfg;
		logic [5:0][31:0]       filt;
		logic [1:0][31:0]       mask;
		logic [2:0][1:0]        txPri;
		logic [2:0]             transmit_request_bit;
		logic [2:0]             transmit_aborted_flag;
		logic [1:0]             txSel;
		logic                   txActive;
		logic [2:0][3:0][31:0]  txMem;
		logic [1:0][3:0][31:0]  rxMem;
		logic [1:0][1:0]        rxMode;
		logic [1:0]             rxFull;
		logic [7:0]             tec;
		logic [7:0]             rec;
		logic [7:0]             bitCnt;
		logic [3:0]             idleCnt;
		logic                   holdOff;
		logic [5:0]             wakeCnt;
		logic                   wakeFlag;
		logic [1:0]             ovlCnt;
		logic [31:0]            rdData;
		logic                   canTxOut;
		logic                   canTxOe;
		logic                   pinsOwned;
		logic                   bitTick;
		logic                   engRxBit;
		logic                   txStart;
		logic [28:0]            txId;
		logic                   txIde;
		logic                   txRtr;
		logic [3:0]             txDlc;
		logic [63:0]            txData;
		logic                   ackEn;
		logic                   errFlagEn;
		logic                   errFrameReq;
		logic                   overloadReq;
	} cmf_state_t;

	cmf_state_t s_reg;
	cmf_state_t s_next;
	logic [NUM_FILT-1:0] filtHit;

	for (genvar i = 0; i < NUM_FILT; i++) begin : g_filt
		cmf_accept_filter #(
			.IW(ID_W),
			.EW(EID_W)
		) u_filt (
			.rxId      (engRxId),
			.rxIde     (engRxIde),
			.filtWord  (s_reg.filt[i]),
			.maskWord  (s_reg.mask[(i < FILT_BUF0) ? 0 : 1]),
			.ignoreIde (s_reg.rxMode[(i < FILT_BUF0) ? 0 : 1] != 2'h0),
			.match     (filtHit[i])
		);
	end

	always_comb begin
		logic       cfgOpen;
		logic       online;
		logic       txCapable;
		logic       busIdle;
		logic       filtOn;
		logic       wakeDom;
		logic       rxEff;
		logic [7:0] bitLimit;
		logic [1:0] best;
		logic       found;
		logic [1:0] bufIdx;
		logic [1:0] wordIdx;
		logic [1:0] hit;
		logic       stored;
		logic [31:0] rd;
		cfgOpen   = 1'b0;
		online    = 1'b0;
		txCapable = 1'b0;
		busIdle   = 1'b0;
		filtOn    = 1'b0;
		wakeDom   = 1'b0;
		rxEff     = RECESSIVE;
		bitLimit  = '0;
		best      = '0;
		found     = 1'b0;
		bufIdx    = regAddr[3:2];
		wordIdx   = regAddr[1:0];
		hit       = '0;
		stored    = 1'b0;
		rd        = '0;

		s_next             = s_reg;
		s_next.txStart     = 1'b0;
		s_next.errFrameReq = 1'b0;
		s_next.overloadReq = 1'b0;
		s_next.bitTick     = 1'b0;

		cfgOpen   = (s_reg.curMode == MODE_INIT);
		online    = (s_reg.curMode != MODE_INIT) && (s_reg.curMode != MODE_DISABLE);
		txCapable = (s_reg.curMode == MODE_NORMAL) || (s_reg.curMode == MODE_LOOPBACK);
		busIdle   = (s_reg.idleCnt == IDLE_BITS);

		// Register writes; hardware events below take precedence
		if (regWrEn) begin
			if (regAddr == ADDR_CTRL) begin
				s_next.reqMode = regWrData[REQ_LSB +: 3];
				if (cfgOpen)
					s_next.ctrlHi = regWrData[HI_LSB +: 5];
			end
			if (cfgOpen) begin
				if (regAddr == ADDR_CFG1)
					s_next.bitCfg = regWrData[7:0];
				if (regAddr == ADDR_CFG2)
					s_next.cfg2 = regWrData;
				if (regAddr == ADDR_INTCFG)
					s_next.intCfg = regWrData;
				for (int i = 0; i < NUM_FILT; i++) begin
					if (regAddr == ADDR_FILT0 + 7'(i))
						s_next.filt[i] = regWrData;
				end
				for (int i = 0; i < NUM_RX; i++) begin
					if (regAddr == ADDR_MASK0 + 7'(i))
						s_next.mask[i] = regWrData;
				end
			end
			if (regAddr == ADDR_STATUS && regWrData[0])
				s_next.wakeFlag = 1'b0;
			for (int i = 0; i < NUM_RX; i++) begin
				if (regAddr == ADDR_RXCON0 + 7'(i)) begin
					s_next.rxMode[i] = regWrData[RXM_LSB +: 2];
					if (!regWrData[RXFUL_BIT])
						s_next.rxFull[i] = 1'b0;
				end
			end
			for (int i = 0; i < NUM_TX; i++) begin
				if (regAddr == ADDR_TXCON0 + 7'(i)) begin
					s_next.txPri[i] = regWrData[1:0];
					if (regWrData[TRANSMIT_REQUEST_BIT_BIT]) begin
						s_next.transmit_request_bit[i] = 1'b1;
						s_next.transmit_aborted_flag[i] = 1'b0;
					end else if (s_reg.transmit_request_bit[i] && !(s_reg.txActive && s_reg.txSel == 2'(i))) begin
						// A frame already on the wire cannot be pulled back
						s_next.transmit_request_bit[i] = 1'b0;
						s_next.transmit_aborted_flag[i] = 1'b1;
					end
				end
			end
			if (regAddr[6:4] == PAGE_TXMEM && bufIdx < 2'(NUM_TX))
				s_next.txMem[bufIdx][wordIdx] = regWrData;
		end

		// Reads: data stands in the following cycle only
		if (regRdEn) begin
			case (regAddr)
				ADDR_CTRL:   rd = 32'({s_reg.ctrlHi, s_reg.reqMode, s_reg.curMode} << CUR_LSB);
				ADDR_CFG1:   rd = {24'h000000, s_reg.bitCfg};
				ADDR_CFG2:   rd = s_reg.cfg2;
				ADDR_INTCFG: rd = s_reg.intCfg;
				ADDR_STATUS: rd = {8'h00, s_reg.rec, s_reg.tec, 7'h00, s_reg.wakeFlag};
				default: begin
					for (int i = 0; i < NUM_RX; i++) begin
						if (regAddr == ADDR_RXCON0 + 7'(i))
							rd = 32'({s_reg.rxFull[i], s_reg.rxMode[i]} << RXM_LSB);
						if (regAddr == ADDR_MASK0 + 7'(i))
							rd = s_reg.mask[i];
					end
					for (int i = 0; i < NUM_TX; i++) begin
						if (regAddr == ADDR_TXCON0 + 7'(i))
							rd = 32'({s_reg.transmit_aborted_flag[i], 2'h0, s_reg.transmit_request_bit[i], 1'b0, s_reg.txPri[i]});
					end
					for (int i = 0; i < NUM_FILT; i++) begin
						if (regAddr == ADDR_FILT0 + 7'(i))
							rd = s_reg.filt[i];
					end
					if (regAddr[6:4] == PAGE_TXMEM && bufIdx < 2'(NUM_TX))
						rd = s_reg.txMem[bufIdx][wordIdx];
					if (regAddr[6:4] == PAGE_RXMEM && bufIdx < 2'(NUM_RX))
						rd = s_reg.rxMem[bufIdx][wordIdx];
				end
			endcase
		end
		s_next.rdData = rd;

		// Bit timing, clamped at the fastest legal rate
		bitLimit = (s_reg.bitCfg < BITCFG_MIN) ? BITCFG_MIN : s_reg.bitCfg;
		if (s_reg.bitCnt >= bitLimit) begin
			s_next.bitCnt  = '0;
			s_next.bitTick = 1'b1;
		end else begin
			s_next.bitCnt = s_reg.bitCnt + 8'h01;
		end

		// Idle detection on the line the engine really sees
		rxEff = (s_reg.curMode == MODE_LOOPBACK) ? engTxBit : netRxLine;
		if (s_reg.bitTick) begin
			if (rxEff == DOMINANT)
				s_next.idleCnt = '0;
			else if (!busIdle)
				s_next.idleCnt = s_reg.idleCnt + 4'h1;
		end

		// Mode change only from offline or on an idle bus with no send running
		if (s_reg.reqMode != s_reg.curMode && (!online || (busIdle && !engTxBusy && !s_reg.txActive))) begin
			s_next.curMode = s_reg.reqMode;
			if (s_reg.reqMode == MODE_NORMAL || s_reg.reqMode == MODE_LOOPBACK) begin
				s_next.holdOff = 1'b1;
				s_next.idleCnt = '0;
			end
		end
		if (s_reg.holdOff && busIdle)
			s_next.holdOff = 1'b0;

		// Disable during the start-up wait kills queued frames
		if (s_reg.holdOff && s_reg.reqMode == MODE_DISABLE) begin
			s_next.transmit_aborted_flag   = s_reg.transmit_aborted_flag | s_reg.transmit_request_bit;
			s_next.transmit_request_bit   = '0;
			s_next.holdOff = 1'b0;
		end

		// Wake detection; filter only while asleep or in disable mode, stops glitches waking us
		filtOn = s_reg.cfg2[WAKE_LINE_FILTER_ENABLE_BIT] && (cpuSleep || s_reg.curMode == MODE_DISABLE);
		if (netRxLine == DOMINANT)
			s_next.wakeCnt = (s_reg.wakeCnt == WAKE_CNT_MAX) ? s_reg.wakeCnt : s_reg.wakeCnt + 6'h01;
		else
			s_next.wakeCnt = '0;
		wakeDom = filtOn ? (s_reg.wakeCnt == WAKE_CNT_MAX) : (netRxLine == DOMINANT);
		if ((s_reg.curMode == MODE_DISABLE || cpuSleep) && wakeDom)
			s_next.wakeFlag = 1'b1;

		// Transmit arbitration: highest priority, lowest index on a tie
		for (int i = 0; i < NUM_TX; i++) begin
			if (s_reg.transmit_request_bit[i] && (!found || s_reg.txPri[i] > s_reg.txPri[best])) begin
				found = 1'b1;
				best  = 2'(i);
			end
		end
		if (engTxDone && s_reg.txActive) begin
			s_next.transmit_request_bit[s_reg.txSel] = 1'b0;
			s_next.txActive           = 1'b0;
		end else if (engTxErr && s_reg.txActive) begin
			s_next.txActive = 1'b0;
			if (s_reg.curMode != MODE_LISTEN)
				s_next.tec = s_reg.tec + 8'h01;
		end else if (txCapable && !s_reg.holdOff && busIdle && found && !engTxBusy && !s_reg.txActive
			&& s_reg.reqMode == s_reg.curMode) begin
			s_next.txActive = 1'b1;
			s_next.txSel    = best;
			s_next.txStart  = 1'b1;
			s_next.txIde    = s_reg.txMem[best][0][IDE_BIT];
			s_next.txRtr    = s_reg.txMem[best][0][RTR_BIT];
			// Base frames drop the extension bits
			s_next.txId     = s_reg.txMem[best][0][IDE_BIT] ? s_reg.txMem[best][0][ID_W-1:0]
				: {s_reg.txMem[best][0][ID_W-1:EID_W], {EID_W{1'b0}}};
			s_next.txDlc    = (s_reg.txMem[best][1][3:0] > DLC_MAX) ? DLC_MAX : s_reg.txMem[best][1][3:0];
			s_next.txData   = {s_reg.txMem[best][3], s_reg.txMem[best][2]};
		end

		// Reception; buffer 0 has priority over buffer 1
		hit[0] = (|filtHit[FILT_BUF0-1:0]) || (s_reg.rxMode[0] == RXM_ANY);
		hit[1] = (|filtHit[NUM_FILT-1:FILT_BUF0]) || (s_reg.rxMode[1] == RXM_ANY);
		if (online && (engRxValid || engRxErr)) begin
			for (int b = 0; b < NUM_RX; b++) begin
				if (!stored && hit[b] && !s_reg.rxFull[b] && (!engRxErr || s_reg.rxMode[b] == RXM_ANY)) begin
					stored             = 1'b1;
					s_next.rxFull[b]   = 1'b1;
					s_next.rxMem[b][0] = 32'({engRxIde, engRxRtr, engRxId});
					s_next.rxMem[b][1] = {28'h0000000, (engRxDlc > DLC_MAX) ? DLC_MAX : engRxDlc};
					s_next.rxMem[b][2] = engRxData[31:0];
					s_next.rxMem[b][3] = engRxData[63:32];
				end
			end
		end
		if (online && engRxValid && !engRxErr && engRxRtr) begin
			for (int i = 0; i < NUM_TX; i++) begin
				if (!s_reg.txMem[i][0][RTR_BIT] && s_reg.txMem[i][0][IDE_BIT] == engRxIde
					&& s_reg.txMem[i][0][ID_W-1:EID_W] == engRxId[ID_W-1:EID_W]
					&& (!engRxIde || s_reg.txMem[i][0][EID_W-1:0] == engRxId[EID_W-1:0])) begin
					s_next.transmit_request_bit[i] = 1'b1;
					s_next.transmit_aborted_flag[i] = 1'b0;
				end
			end
		end
		if (online && engRxErr && s_reg.curMode != MODE_LISTEN) begin
			s_next.errFrameReq = 1'b1;
			s_next.rec         = s_reg.rec + 8'h01;
		end

		// Overload: illegal dominant or no free receive buffer
		if (engSof)
			s_next.ovlCnt = '0;
		else if (online && s_reg.curMode != MODE_LISTEN && s_reg.ovlCnt < OVL_MAX
			&& (engOverloadCond || (engRxValid && (&s_reg.rxFull)))) begin
			s_next.overloadReq = 1'b1;
			s_next.ovlCnt      = s_reg.ovlCnt + 2'h1;
		end

		if (s_reg.curMode == MODE_INIT) begin
			s_next.tec = '0;
			s_next.rec = '0;
		end

		// Pin ownership and engine steering
		s_next.canTxOe   = (s_reg.curMode == MODE_NORMAL);
		s_next.canTxOut  = (s_reg.curMode == MODE_NORMAL) ? engTxBit : RECESSIVE;
		s_next.pinsOwned = (s_reg.curMode == MODE_NORMAL) || (s_reg.curMode == MODE_LISTEN);
		s_next.engRxBit  = online ? rxEff : RECESSIVE;
		s_next.ackEn     = txCapable;
		s_next.errFlagEn = txCapable;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg          <= '0;
			s_reg.reqMode  <= MODE_INIT;
			s_reg.curMode  <= MODE_INIT;
			s_reg.bitCfg   <= BITCFG_RST;
			s_reg.canTxOut <= RECESSIVE;
			s_reg.engRxBit <= RECESSIVE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign regRdData     = s_reg.rdData;
	assign canTxOut      = s_reg.canTxOut;
	assign canTxOe       = s_reg.canTxOe;
	assign pinsOwned     = s_reg.pinsOwned;
	assign bitTick       = s_reg.bitTick;
	assign engRxBit      = s_reg.engRxBit;
	assign txStart       = s_reg.txStart;
	assign txId          = s_reg.txId;
	assign txIde         = s_reg.txIde;
	assign txRtr         = s_reg.txRtr;
	assign txDlc         = s_reg.txDlc;
	assign txData        = s_reg.txData;
	assign ackEnable     = s_reg.ackEn;
	assign errFlagEnable = s_reg.errFlagEn;
	assign errFrameReq   = s_reg.errFrameReq;
	assign overloadReq   = s_reg.overloadReq;
	assign wakeFlag      = s_reg.wakeFlag;

endmodule

// ### cmf_bus_node.sv
module cmf_bus_node
	import cmf_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       burstReq,
	input  wire logic [7:0] burstLen,
	input  wire logic       canTxOut,
	input  wire logic       canTxOe,
	output logic            netRxLine
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] domLeft_reg;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			domLeft_reg <= 8'h00;
		else if (burstReq)
			domLeft_reg <= burstLen;
		else if (domLeft_reg != 8'h00)
			domLeft_reg <= domLeft_reg - 8'h01;
	end

	// Wired-AND: any dominant driver wins, idle bus floats recessive
	assign netRxLine = (domLeft_reg == 8'h00) & (canTxOe ? canTxOut : RECESSIVE);
endmodule

// ### cmf_mode_frame_ctrl_chk.sv
module cmf_mode_frame_ctrl_chk
	import cmf_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        regRdEn,
	input wire logic        regWrEn,
	input wire logic [31:0] regRdData,
	input wire logic        engTxBit,
	input wire logic        engRxBit,
	input wire logic        engSof,
	input wire logic        engRxErr,
	input wire logic        canTxOut,
	input wire logic        canTxOe,
	input wire logic        pinsOwned,
	input wire logic        txStart,
	input wire logic [28:0] txId,
	input wire logic        txIde,
	input wire logic [3:0]  txDlc,
	input wire logic        ackEnable,
	input wire logic        errFlagEnable,
	input wire logic        errFrameReq,
	input wire logic        overloadReq,
	input wire logic        wakeFlag
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	logic [1:0] ovlRun_reg;

	// Saturates so a runaway design cannot wrap back under the limit
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			ovlRun_reg <= 2'h0;
		else if (engSof)
			ovlRun_reg <= 2'h0;
		else if (overloadReq && ovlRun_reg != 2'h3)
			ovlRun_reg <= ovlRun_reg + 2'h1;
	end

	sequence loopSteady;
		(ackEnable && !pinsOwned)[*3];
	endsequence
	sequence offSteady;
		(!ackEnable && !pinsOwned)[*2];
	endsequence
	sequence listenSteady;
		(pinsOwned && !canTxOe)[*2];
	endsequence

	chk_oe_online: assert property (canTxOe |-> pinsOwned && ackEnable)
		else $error("transmit enable outside normal mode");
	chk_tx_released: assert property (!canTxOe |-> canTxOut == RECESSIVE)
		else $error("transmit pin not recessive while released");
	chk_rd_window: assert property (!$past(regRdEn) |-> regRdData == 32'h0)
		else $error("read data outside its cycle");
	chk_err_frame: assert property (errFrameReq |-> $past(engRxErr))
		else $error("error frame without receive error");
	chk_listen_quiet: assert property (listenSteady |-> !ackEnable && !errFlagEnable && !errFrameReq)
		else $error("listen-only node not passive");
	chk_loop_echo: assert property (loopSteady |-> engRxBit == $past(engTxBit))
		else $error("loopback receive bit mismatch");
	chk_offline_rx: assert property (offSteady |-> engRxBit == RECESSIVE)
		else $error("receive path active while offline");
	chk_ovl_limit: assert property (ovlRun_reg <= OVL_MAX)
		else $error("too many overload frames in a row");
	chk_dlc_clamp: assert property (txStart |-> txDlc <= DLC_MAX)
		else $error("transmit length above eight");
	chk_base_id: assert property (txStart && !txIde |-> txId[17:0] == 18'h0)
		else $error("base frame carries extension bits");
	chk_wake_sticky: assert property ($past(wakeFlag) && !$past(regWrEn) |-> wakeFlag)
		else $error("wake flag dropped without a write");
endmodule

bind cmf_mode_frame_ctrl cmf_mode_frame_ctrl_chk chk (.ref_clk, .rst_n, .regRdEn, .regWrEn, .regRdData,
	.engTxBit, .engRxBit, .engSof, .engRxErr, .canTxOut, .canTxOe, .pinsOwned, .txStart, .txId, .txIde,
	.txDlc, .ackEnable, .errFlagEnable, .errFrameReq, .overloadReq, .wakeFlag);

// ### cmf_mode_frame_ctrl_test.sv
module cmf_mode_frame_ctrl_test
	import cmf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        ref_clk, rst_n, regWrEn, regRdEn, cpuSleep, engTxBit, engSof, engRxValid, engRxErr;
	logic        engTxBusy, engTxDone, engOverloadCond, burstReq, netRxLine, canTxOut, canTxOe;
	logic        pinsOwned, engRxBit, txStart, txIde, ackEnable, errFrameReq, overloadReq, wakeFlag;
	logic        engRxIde, engRxRtr, bitTick;
	logic [6:0]  regAddr;
	logic [31:0] regWrData, regRdData;
	logic [28:0] engRxId, txId;
	logic [3:0]  engRxDlc, txDlc;
	logic [63:0] engRxData, txData;
	logic [7:0]  burstLen;
	int          failCount = 0, totalChecks = 0, errCount = 0, ovlCount = 0, startCount = 0, n;

	cmf_mode_frame_ctrl DUT (.ref_clk, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
		.cpuSleep, .netRxLine, .canTxOut, .canTxOe, .pinsOwned, .bitTick, .engTxBit, .engRxBit, .engSof,
		.engRxValid, .engRxErr, .engRxId, .engRxIde, .engRxRtr, .engRxDlc, .engRxData,
		.engTxErr(1'b0), .engTxBusy, .engTxDone, .engOverloadCond, .txStart, .txId, .txIde, .txRtr(),
		.txDlc, .txData, .ackEnable, .errFlagEnable(), .errFrameReq, .overloadReq, .wakeFlag);

	cmf_bus_node node (.ref_clk, .rst_n, .burstReq, .burstLen, .canTxOut, .canTxOe, .netRxLine);

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		errCount <= errCount + int'(errFrameReq);
		ovlCount <= ovlCount + int'(overloadReq);
		startCount <= startCount + int'(txStart);
	end

	task automatic completeRun;
		if (failCount == 0 && totalChecks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		totalChecks++;
		if (g !== e) begin
			failCount++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chkb(input string nm, input logic e, input logic g);
		chk(nm, 32'(e), 32'(g));
	endtask

	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge ref_clk);
		regWrEn <= 1'b0;
		// Gap edge so a following write never re-drives the strobe in the same step
		@(posedge ref_clk);
	endtask

	// Data is taken at the edge closing its only valid cycle
	task automatic rdc(input logic [6:0] a, input logic [31:0] e);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge ref_clk);
		regRdEn <= 1'b0;
		@(posedge ref_clk);
		chk("regRdData", e, regRdData);
	endtask

	task automatic burst(input logic [7:0] len);
		burstLen <= len;
		burstReq <= 1'b1;
		@(posedge ref_clk);
		burstReq <= 1'b0;
	endtask

	task automatic pulse(input logic e, input logic o, input logic s);
		engRxErr <= e;
		engOverloadCond <= o;
		engSof <= s;
		@(posedge ref_clk);
		{engRxErr, engOverloadCond, engSof} <= 3'h0;
		repeat (2) @(posedge ref_clk);
	endtask

	task automatic waitPins(input logic po, input logic ae, output int k);
		k = 0;
		while (!(pinsOwned === po && ackEnable === ae) && k < 3000) begin
			@(posedge ref_clk);
			k++;
		end
		chkb("modeReached", 1'b1, k < 3000);
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		failCount++;
		completeRun();
	end

	initial begin
		rst_n = 1'b0;
		{regWrEn, regRdEn, cpuSleep, engSof, engRxValid, engRxErr, engTxBusy, engTxDone} = 8'h00;
		{engOverloadCond, burstReq, regAddr, regWrData, engRxId, engRxDlc, engRxData, burstLen} = '0;
		{engRxIde, engRxRtr} = 2'h0;
		engTxBit = 1'b1;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rdc(ADDR_CTRL, 32'h0000_0480);
		wr(ADDR_CFG2, 32'h0000_4000);
		rdc(ADDR_CFG2, 32'h0000_4000);
		wr(ADDR_CFG1, 32'h0000_0010);
		rdc(ADDR_CFG1, 32'h0000_0010);
		while (bitTick !== 1'b1)
			@(posedge ref_clk);
		n = 1;
		@(posedge ref_clk);
		while (bitTick !== 1'b1 && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		chk("bitPeriod", 32'h0000_0028, 32'(n));
		wr(7'h20, 32'h0AAC_1234);
		wr(7'h21, 32'h0000_000F);
		wr(7'h22, 32'h4433_2211);
		wr(7'h23, 32'h8877_6655);
		wr(ADDR_MASK0, 32'h1FFF_FFFF);
		wr(ADDR_FILT0, 32'h0ABC_0000);
		rdc(ADDR_FILT0, 32'h0ABC_0000);
		wr(ADDR_CTRL, 32'h0000_0000);
		rdc(ADDR_CTRL, 32'h0000_0000);
		@(posedge ref_clk);
		chkb("canTxOe", 1'b1, canTxOe);
		wr(ADDR_CFG1, 32'h0000_0050);
		rdc(ADDR_CFG1, 32'h0000_0010);
		wr(ADDR_TXCON0, 32'h0000_0008);
		n = 0;
		while (txStart !== 1'b1 && n < 2000) begin
			@(posedge ref_clk);
			n++;
		end
		chkb("txIdleWait", 1'b1, n >= 360 && n < 2000);
		chk("txId", 32'h0AAC_0000, 32'(txId));
		chk("txDlc", 32'h0000_0008, 32'(txDlc));
		chk("txData", 32'h4433_2211, txData[31:0]);
		chk("txData", 32'h8877_6655, txData[63:32]);
		engTxDone <= 1'b1;
		@(posedge ref_clk);
		engTxDone <= 1'b0;
		@(posedge ref_clk);
		rdc(ADDR_TXCON0, 32'h0000_0000);
		engRxId <= 29'h0ABC_0000;
		engRxDlc <= 4'h4;
		engRxData <= 64'h0000_0000_DDCC_BBAA;
		engRxValid <= 1'b1;
		@(posedge ref_clk);
		engRxValid <= 1'b0;
		@(posedge ref_clk);
		rdc(ADDR_RXCON0, 32'h0000_0080);
		rdc(7'h30, 32'h0ABC_0000);
		rdc(7'h32, 32'hDDCC_BBAA);
		engRxId <= 29'h0AAC_0000;
		engRxRtr <= 1'b1;
		engRxValid <= 1'b1;
		@(posedge ref_clk);
		{engRxValid, engRxRtr} <= 2'h0;
		n = 0;
		while (txStart !== 1'b1 && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		chkb("remoteAnswer", 1'b1, n < 100);
		chk("remoteId", 32'h0AAC_0000, 32'(txId));
		engTxDone <= 1'b1;
		@(posedge ref_clk);
		engTxDone <= 1'b0;
		@(posedge ref_clk);
		pulse(1'b1, 1'b0, 1'b0);
		chk("errFrames", 32'h0000_0001, 32'(errCount));
		rdc(ADDR_STATUS, 32'h0001_0000);
		burst(8'hFF);
		// Let a dominant bit be sampled so the idle count is really broken
		repeat (50) @(posedge ref_clk);
		wr(ADDR_CTRL, 32'h0000_0100);
		waitPins(1'b0, 1'b0, n);
		chkb("disableIdleWait", 1'b1, n > 600);
		rdc(ADDR_CTRL, 32'h0000_0120);
		chkb("canTxOe", 1'b0, canTxOe);
		rdc(ADDR_STATUS, 32'h0001_0000);
		cpuSleep <= 1'b1;
		burst(8'h0A);
		repeat (60) @(posedge ref_clk);
		chkb("wakeShort", 1'b0, wakeFlag);
		burst(8'h64);
		repeat (120) @(posedge ref_clk);
		chkb("wakeLong", 1'b1, wakeFlag);
		cpuSleep <= 1'b0;
		wr(ADDR_STATUS, 32'h0000_0001);
		rdc(ADDR_STATUS, 32'h0001_0000);
		wr(ADDR_CTRL, 32'h0000_0000);
		wr(ADDR_TXCON0, 32'h0000_0008);
		repeat (100) @(posedge ref_clk);
		wr(ADDR_CTRL, 32'h0000_0100);
		waitPins(1'b0, 1'b0, n);
		rdc(ADDR_TXCON0, 32'h0000_0040);
		chk("txStarts", 32'h0000_0002, 32'(startCount));
		wr(ADDR_CTRL, 32'h0000_0300);
		repeat (3) @(posedge ref_clk);
		chkb("pinsOwned", 1'b1, pinsOwned);
		pulse(1'b1, 1'b1, 1'b0);
		chk("errFrames", 32'h0000_0001, 32'(errCount));
		chk("overloads", 32'h0000_0000, 32'(ovlCount));
		rdc(ADDR_STATUS, 32'h0001_0000);
		wr(ADDR_CTRL, 32'h0000_0200);
		waitPins(1'b0, 1'b1, n);
		engTxBit <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chkb("engRxBit", 1'b0, engRxBit);
		engTxBit <= 1'b1;
		pulse(1'b0, 1'b0, 1'b1);
		repeat (3) pulse(1'b0, 1'b1, 1'b0);
		chk("overloads", 32'h0000_0002, 32'(ovlCount));
		pulse(1'b0, 1'b0, 1'b1);
		pulse(1'b0, 1'b1, 1'b0);
		chk("overloads", 32'h0000_0003, 32'(ovlCount));
		engTxBusy <= 1'b1;
		wr(ADDR_CTRL, 32'h0000_0400);
		repeat (600) @(posedge ref_clk);
		rdc(ADDR_CTRL, 32'h0000_0440);
		engTxBusy <= 1'b0;
		repeat (600) @(posedge ref_clk);
		rdc(ADDR_CTRL, 32'h0000_0480);
		rdc(ADDR_STATUS, 32'h0000_0000);
		rdc(7'h7F, 32'h0000_0000);
		completeRun();
	end
endmodule
